// File: include/memspace_pkg.sv
package memspace_pkg;
    localparam int PROG_WORDS = 16384;
    localparam int PC_WIDTH = 14;
    localparam int INSTR_WIDTH = 16;
    localparam int DATA_ADDR_WIDTH = 16;
    localparam logic [15:0] REGFILE_BASE = 16'h0000;
    localparam logic [15:0] STD_IO_BASE = 16'h0020;
    localparam logic [15:0] EXT_IO_BASE = 16'h0060;
    localparam logic [15:0] SRAM_BASE = 16'h0100;
    localparam logic [15:0] SRAM_END = 16'h08FF;
    localparam int REGFILE_SIZE = 32;
    localparam int STD_IO_SIZE = 64;
    localparam int EXT_IO_SIZE = 160;
    localparam int SRAM_SIZE = 2048;
    localparam logic [5:0] IO_DATA_OFFSET = 6'h20;
    localparam logic [5:0] BIT_IO_LAST = 6'h1F;
    localparam int DISP_MAX = 63;
    localparam int EE_BYTES = 1024;
    localparam int EE_ADDR_WIDTH = 10;
    // i/o addresses (short form)
    localparam logic [5:0] IO_EE_CTRL = 6'h1F;
    localparam logic [5:0] IO_EE_DATA = 6'h20;
    localparam logic [5:0] IO_EE_PTR_LO = 6'h21;
    localparam logic [5:0] IO_EE_PTR_HI = 6'h22;
    localparam logic [5:0] IO_GPIO0 = 6'h1E;
    localparam logic [5:0] IO_GPIO1 = 6'h2A;
    localparam logic [5:0] IO_GPIO2 = 6'h2B;
    localparam logic [5:0] IO_FLAGS = 6'h1C;
    // control bit positions
    localparam int EE_READ_BIT = 0;
    localparam int EE_STROBE_BIT = 1;
    localparam int EE_ARM_BIT = 2;
    localparam int EE_MODE_LO = 4;
    localparam int EE_MODE_HI = 5;
    localparam logic [7:0] EE_CTRL_MASK = 8'h3F;
    // stall and timing
    localparam logic [2:0] EE_READ_STALL = 3'h4;
    localparam logic [2:0] EE_WRITE_STALL = 3'h2;
    localparam logic [2:0] EE_ARM_WINDOW = 3'h4;
    localparam int CLOCK_HZ = 20000000;
    localparam int EE_WRITE_US = 3400;
    localparam int EE_WRITE_CYCLES = EE_WRITE_US * (CLOCK_HZ / 1000000);
    // pointer modes
    typedef enum logic [2:0] {
        PTR_PLAIN, PTR_POSTINC, PTR_PREDEC, PTR_DISP, PTR_DIRECT
    } addr_mode_type;
    typedef enum logic [1:0] {
        PTR_X, PTR_Y, PTR_Z
    } ptr_sel_type;
endpackage

// File: sim/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
    input wire logic CLOCK,
    input wire logic STALL,
    input wire logic [7:0] RDATA,
    output logic DATA_REQ, DATA_WE,
    output logic [2:0] ADDR_MODE,
    output logic [1:0] PTR_SEL,
    output logic [15:0] DIRECT_ADDR,
    output logic [5:0] DISP,
    output logic [7:0] WDATA,
    output logic IO_REQ, IO_WE,
    output logic [5:0] IO_ADDR,
    output logic BIT_SET, BIT_CLR, BIT_TEST,
    output logic [2:0] BIT_NUM,
    output logic HANG
);
    realtime last_rel;
    initial begin
        last_rel = -1.0;
        {DATA_REQ, DATA_WE, ADDR_MODE, PTR_SEL, DIRECT_ADDR, DISP} = '0;
        {WDATA, IO_REQ, IO_WE, IO_ADDR, BIT_NUM, HANG} = '0;
        {BIT_SET, BIT_CLR, BIT_TEST} = 3'h0;
    end
    // no request is placed while the core is halted, for up to 40 cycles; then HANG is raised and the request goes out
    task automatic wait_free();
        int n;
        n = 0;
        while (STALL !== 1'b0 && n < 40) begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        HANG = (n >= 40);
    endtask
    // hold for cyc edges, release, scramble the idle bus
    task automatic finish(input int cyc, input logic get,
        output logic [7:0] rd);
        repeat (cyc) @(posedge CLOCK);
        #1;
        DATA_REQ = 1'b0;
        IO_REQ = 1'b0;
        {BIT_SET, BIT_CLR, BIT_TEST} = 3'h0;
        DIRECT_ADDR = ~DIRECT_ADDR;
        WDATA = ~WDATA;
        last_rel = $realtime;
        rd = 8'h00;
        if (get) begin
            @(posedge CLOCK);
            #1;
            rd = RDATA;
        end
    endtask
    task automatic data_acc(input logic we, input logic [2:0] mode,
        input logic [1:0] ptr, input logic [15:0] a, input logic [5:0] d,
        input logic [7:0] wd, input int cyc, output logic [7:0] rd);
        wait_free();
        if (last_rel == $realtime) begin
            @(posedge CLOCK);
            #1;
        end
        DATA_WE = we;
        ADDR_MODE = mode;
        PTR_SEL = ptr;
        DIRECT_ADDR = a;
        DISP = d;
        WDATA = wd;
        DATA_REQ = 1'b1;
        finish(cyc, !we, rd);
    endtask
    task automatic io_acc(input logic we, input logic [2:0] bop,
        input logic [5:0] a, input logic [2:0] b, input logic [7:0] wd,
        output logic [7:0] rd);
        wait_free();
        if (last_rel == $realtime) begin
            @(posedge CLOCK);
            #1;
        end
        IO_WE = we;
        {BIT_SET, BIT_CLR, BIT_TEST} = bop;
        IO_ADDR = a;
        BIT_NUM = b;
        WDATA = wd;
        IO_REQ = 1'b1;
        finish(1, !we && bop == 3'h0, rd);
    endtask
    task automatic ee_point(input logic [9:0] a);
        logic [7:0] r;
        io_acc(1'b1, 3'h0, memspace_pkg::IO_EE_PTR_LO, 3'h0, a[7:0], r);
        io_acc(1'b1, 3'h0, memspace_pkg::IO_EE_PTR_HI, 3'h0,
            {6'h00, a[9:8]}, r);
    endtask
    task automatic ee_write(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] r;
        ee_point(a);
        io_acc(1'b1, 3'h0, memspace_pkg::IO_EE_DATA, 3'h0, d, r);
        io_acc(1'b1, 3'h0, memspace_pkg::IO_EE_CTRL, 3'h0, 8'h04, r);
        io_acc(1'b1, 3'h0, memspace_pkg::IO_EE_CTRL, 3'h0, 8'h02, r);
    endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct {
        logic [15:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_type;
    logic CLOCK, RST, PROG_LOAD, DATA_REQ, DATA_WE, IO_REQ, IO_WE, SKIP;
    logic BIT_SET, BIT_CLR, BIT_TEST, STALL, EE_BUSY, HANG;
    logic [13:0] PC, PROG_LOAD_ADDR;
    logic [15:0] PROG_LOAD_DATA, INSTR, DIRECT_ADDR;
    logic [2:0] ADDR_MODE, BIT_NUM;
    logic [1:0] PTR_SEL;
    logic [5:0] DISP, IO_ADDR;
    logic [7:0] WDATA, RDATA, FLAG_EVENTS, REG_OUT, rd;
    logic [13:0] pa [3];
    row_type rows [10];
    int bad_count, num_checks, n;
    memspace_decoder #(.EE_WRITE_TIME(10)) uut (.CLOCK(CLOCK), .RST(RST),
        .PC(PC), .INSTR(INSTR), .PROG_LOAD(PROG_LOAD),
        .PROG_LOAD_ADDR(PROG_LOAD_ADDR), .PROG_LOAD_DATA(PROG_LOAD_DATA),
        .DATA_REQ(DATA_REQ), .DATA_WE(DATA_WE), .ADDR_MODE(ADDR_MODE),
        .PTR_SEL(PTR_SEL), .DIRECT_ADDR(DIRECT_ADDR), .DISP(DISP),
        .REG_SEL(5'h00), .WDATA(WDATA), .RDATA(RDATA), .IO_REQ(IO_REQ),
        .IO_WE(IO_WE), .IO_ADDR(IO_ADDR), .BIT_SET(BIT_SET),
        .BIT_CLR(BIT_CLR), .BIT_TEST(BIT_TEST), .BIT_NUM(BIT_NUM),
        .SKIP(SKIP), .FLAG_EVENTS(FLAG_EVENTS), .REG_OUT(REG_OUT),
        .STALL(STALL), .EE_BUSY(EE_BUSY));
    cpu_model cpu (.CLOCK(CLOCK), .STALL(STALL), .RDATA(RDATA),
        .DATA_REQ(DATA_REQ), .DATA_WE(DATA_WE), .ADDR_MODE(ADDR_MODE),
        .PTR_SEL(PTR_SEL), .DIRECT_ADDR(DIRECT_ADDR), .DISP(DISP),
        .WDATA(WDATA), .IO_REQ(IO_REQ), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR),
        .BIT_SET(BIT_SET), .BIT_CLR(BIT_CLR), .BIT_TEST(BIT_TEST),
        .BIT_NUM(BIT_NUM), .HANG(HANG));
    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        bad_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) fail($sformatf("got %h expected %h", g, e));
    endtask
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) fail("flag differs");
    endtask
    task automatic chk_cnt(input int g, input int e);
        num_checks++;
        if (g != e) fail($sformatf("%0d cycles, expected %0d", g, e));
    endtask
    task automatic dacc(input logic we, input logic [15:0] a,
        input logic [7:0] d);
        n = (a >= memspace_pkg::SRAM_BASE && a <= memspace_pkg::SRAM_END)
            ? 2 : 1;
        cpu.data_acc(we, memspace_pkg::PTR_DIRECT, 2'h0, a, 6'h00, d, n, rd);
    endtask
    task automatic bop(input logic [2:0] op, input logic [5:0] a,
        input logic [2:0] b);
        cpu.io_acc(1'b0, op, a, b, 8'h00, rd);
    endtask
    task automatic ctl(input logic we, input logic [7:0] d);
        cpu.io_acc(we, 3'h0, memspace_pkg::IO_EE_CTRL, 3'h0, d, rd);
    endtask
    task automatic stall_len(output int c);
        c = 0;
        while (STALL === 1'b1 && c < 20) begin
            @(posedge CLOCK);
            #1;
            c++;
        end
    endtask
    task automatic wait_idle();
        n = 0;
        while (EE_BUSY !== 1'b0 && n < 40) begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        if (n >= 40) begin
            fail("write never finished");
            summarize();
        end
    endtask
    task automatic ee_read(input logic [9:0] a, input logic [7:0] e);
        int c;
        cpu.ee_point(a);
        ctl(1'b1, 8'h01);
        stall_len(c);
        chk_cnt(c, 4);
        cpu.io_acc(1'b0, 3'h0, memspace_pkg::IO_EE_DATA, 3'h0, 8'h00, rd);
        chk_byte(rd, e);
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    always @(posedge HANG) begin
        fail("core held off too long");
        summarize();
    end
    initial begin
        {RST, PC, PROG_LOAD, PROG_LOAD_ADDR, PROG_LOAD_DATA} = {1'b1, 45'h0};
        FLAG_EVENTS = 8'h00;
        bad_count = 0;
        num_checks = 0;
        rows = '{'{16'h0005, 8'h11, 8'h11}, '{16'h003E, 8'hA5, 8'hA5},
            '{16'h004A, 8'h3C, 8'h3C}, '{16'h004B, 8'hC3, 8'hC3},
            '{16'h0060, 8'h77, 8'h00}, '{16'h00FF, 8'h66, 8'h00},
            '{16'h0100, 8'h12, 8'h12}, '{16'h08FF, 8'h34, 8'h34},
            '{16'h0900, 8'h56, 8'h00}, '{16'hFFFF, 8'h78, 8'h00}};
        pa = '{14'h0000, 14'h2000, 14'h3FFF};
        repeat (5) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        foreach (rows[i]) begin
            dacc(1'b1, rows[i].addr, rows[i].wd);
            dacc(1'b0, rows[i].addr, 8'h00);
            chk_byte(rd, rows[i].exp);
        end
        for (int i = 0; i < 3; i++) begin
            {PROG_LOAD, PROG_LOAD_ADDR, PROG_LOAD_DATA} = {1'b1, pa[i],
                2'b10, pa[i]};
            @(posedge CLOCK);
            #1;
        end
        PROG_LOAD = 1'b0;
        for (int i = 0; i < 3; i++) begin
            PC = pa[i];
            @(posedge CLOCK);
            #1;
            chk_byte(INSTR[15:8], {2'b10, pa[i][13:8]});
            chk_byte(INSTR[7:0], pa[i][7:0]);
        end
        cpu.io_acc(1'b1, 3'h0, memspace_pkg::IO_GPIO2, 3'h0, 8'h9C, rd);
        dacc(1'b0, 16'h004B, 8'h00);
        chk_byte(rd, 8'h9C);
        // pointer modes
        dacc(1'b1, 16'h001A, 8'h05);
        dacc(1'b1, 16'h001B, 8'h00);
        cpu.data_acc(1'b0, memspace_pkg::PTR_PLAIN, 2'h0, 16'h0, 6'h0,
            8'h0, 1, rd);
        chk_byte(rd, 8'h11);
        dacc(1'b1, 16'h001E, 8'h00);
        dacc(1'b1, 16'h001F, 8'h01);
        for (int i = 0; i < 2; i++) begin
            cpu.data_acc(1'b1, memspace_pkg::PTR_POSTINC, 2'h2, 16'h0, 6'h0,
                8'h33 + 8'(i * 17), 2, rd);
        end
        dacc(1'b0, 16'h0100, 8'h00);
        chk_byte(rd, 8'h33);
        dacc(1'b0, 16'h001E, 8'h00);
        chk_byte(rd, 8'h02);
        cpu.data_acc(1'b0, memspace_pkg::PTR_PREDEC, 2'h2, 16'h0, 6'h0,
            8'h0, 2, rd);
        chk_byte(rd, 8'h44);
        dacc(1'b1, 16'h001C, 8'h00);
        dacc(1'b1, 16'h001D, 8'h01);
        dacc(1'b1, 16'h013F, 8'h5A);
        cpu.data_acc(1'b0, memspace_pkg::PTR_DISP, 2'h1, 16'h0, 6'h3F,
            8'h0, 2, rd);
        chk_byte(rd, 8'h5A);
        // bit operations
        cpu.io_acc(1'b1, 3'h0, memspace_pkg::IO_GPIO0, 3'h0, 8'h00, rd);
        bop(3'h4, memspace_pkg::IO_GPIO0, 3'h3);
        bop(3'h4, memspace_pkg::IO_GPIO0, 3'h7);
        chk_byte(REG_OUT, 8'h88);
        bop(3'h2, memspace_pkg::IO_GPIO0, 3'h3);
        chk_byte(REG_OUT, 8'h80);
        bop(3'h5, memspace_pkg::IO_GPIO0, 3'h7);
        chk_bit(SKIP, 1'b1);
        bop(3'h1, memspace_pkg::IO_GPIO0, 3'h7);
        chk_bit(SKIP, 1'b0);
        bop(3'h1, memspace_pkg::IO_GPIO0, 3'h0);
        chk_bit(SKIP, 1'b1);
        bop(3'h4, memspace_pkg::IO_GPIO1, 3'h0);
        dacc(1'b0, 16'h004A, 8'h00);
        chk_byte(rd, 8'h3C);
        // clear-on-one flags
        FLAG_EVENTS = 8'h0F;
        @(posedge CLOCK);
        #1;
        FLAG_EVENTS = 8'h00;
        bop(3'h4, memspace_pkg::IO_FLAGS, 3'h1);
        dacc(1'b0, 16'h003C, 8'h00);
        chk_byte(rd, 8'h0D);
        dacc(1'b1, 16'h003C, 8'h05);
        dacc(1'b0, 16'h003C, 8'h00);
        chk_byte(rd, 8'h08);
        // eeprom write, read back, refused strobes
        cpu.ee_write(10'h3FF, 8'hA7);
        stall_len(n);
        chk_cnt(n, 2);
        chk_bit(EE_BUSY, 1'b1);
        ctl(1'b0, 8'h00);
        chk_byte(rd & 8'h06, 8'h02);
        wait_idle();
        ctl(1'b0, 8'h00);
        chk_byte(rd & 8'h02, 8'h00);
        ee_read(10'h3FF, 8'hA7);
        ctl(1'b1, 8'h02);
        @(posedge CLOCK);
        #1;
        chk_bit(EE_BUSY, 1'b0);
        ctl(1'b1, 8'h04);
        repeat (6) @(posedge CLOCK);
        #1;
        ctl(1'b0, 8'h00);
        chk_byte(rd & 8'h04, 8'h00);
        ctl(1'b1, 8'h02);
        @(posedge CLOCK);
        #1;
        chk_bit(EE_BUSY, 1'b0);
        // reset while a write runs
        cpu.ee_write(10'h001, 8'h3B);
        RST = 1'b1;
        @(posedge CLOCK);
        #1;
        RST = 1'b0;
        chk_bit(EE_BUSY, 1'b1);
        wait_idle();
        ee_read(10'h001, 8'h3B);
        summarize();
    end
endmodule

// File: src/memspace_decoder.sv
`timescale 1ns/100ps
module memspace_decoder #(
    parameter int EE_WRITE_TIME = memspace_pkg::EE_WRITE_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [13:0] PC,
    output logic [15:0] INSTR,
    input wire logic PROG_LOAD,
    input wire logic [13:0] PROG_LOAD_ADDR,
    input wire logic [15:0] PROG_LOAD_DATA,
    input wire logic DATA_REQ,
    input wire logic DATA_WE,
    input wire logic [2:0] ADDR_MODE,
    input wire logic [1:0] PTR_SEL,
    input wire logic [15:0] DIRECT_ADDR,
    input wire logic [5:0] DISP,
    input wire logic [4:0] REG_SEL,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    input wire logic IO_REQ,
    input wire logic IO_WE,
    input wire logic [5:0] IO_ADDR,
    input wire logic BIT_SET,
    input wire logic BIT_CLR,
    input wire logic BIT_TEST,
    input wire logic [2:0] BIT_NUM,
    output logic SKIP,
    input wire logic [7:0] FLAG_EVENTS,
    output logic [7:0] REG_OUT,
    output logic STALL,
    output logic EE_BUSY
);
    localparam logic [2:0] ONE3 = 3'h1;
    if (EE_WRITE_TIME < 1) begin : g_bad_write_time
        $error("eeprom write time must be at least one cycle");
    end
    // memories
    logic [15:0] prog_mem [memspace_pkg::PROG_WORDS];
    logic [7:0] reg_file [memspace_pkg::REGFILE_SIZE];
    logic [7:0] sram [memspace_pkg::SRAM_SIZE];
    logic [7:0] ee_mem [memspace_pkg::EE_BYTES];
    logic [15:0] instr_reg;
    logic [7:0] rdata_reg;
    logic [7:0] gpio_reg [3];
    logic [7:0] flags_reg;
    logic [7:0] ee_data_reg;
    logic [9:0] ee_ptr_reg;
    logic [1:0] ee_mode_reg;
    logic ee_arm_reg;
    logic ee_strobe_reg;
    logic [2:0] arm_cnt_reg;
    logic [2:0] stall_reg;
    logic [31:0] wr_cnt_reg;
    logic [9:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic sram_phase_reg;
    logic skip_reg;
    // pointer registers in R26..R31
    function automatic logic [15:0] ptr_val(input logic [1:0] sel);
        logic [4:0] lo;
        lo = 5'h1A + {2'h0, sel, 1'b0};
        return {reg_file[lo + 5'h01], reg_file[lo]};
    endfunction
    function automatic logic [5:0] data_to_io(input logic [15:0] a);
        return 6'(a - 16'(memspace_pkg::IO_DATA_OFFSET));
    endfunction
    // effective data address
    wire [15:0] base_ptr = ptr_val(PTR_SEL);
    wire [15:0] disp_sum = base_ptr + {10'h000, DISP};
    wire disp_ok = PTR_SEL != 2'(memspace_pkg::PTR_X);
    wire [15:0] pre_dec = base_ptr - 16'h0001;
    wire [15:0] post_inc = base_ptr + 16'h0001;
    logic [15:0] eff_addr;
    always_comb begin
        unique case (memspace_pkg::addr_mode_type'(ADDR_MODE))
            memspace_pkg::PTR_PLAIN: eff_addr = base_ptr;
            memspace_pkg::PTR_POSTINC: eff_addr = base_ptr;
            memspace_pkg::PTR_PREDEC: eff_addr = pre_dec;
            memspace_pkg::PTR_DISP:
                eff_addr = disp_ok ? disp_sum : base_ptr;
            memspace_pkg::PTR_DIRECT: eff_addr = DIRECT_ADDR;
            default: eff_addr = DIRECT_ADDR;
        endcase
    end
    // region decode
    wire in_regs = eff_addr < memspace_pkg::STD_IO_BASE;
    wire in_stdio = !in_regs && eff_addr < memspace_pkg::EXT_IO_BASE;
    wire in_extio = eff_addr >= memspace_pkg::EXT_IO_BASE
        && eff_addr < memspace_pkg::SRAM_BASE;
    wire in_sram = eff_addr >= memspace_pkg::SRAM_BASE
        && eff_addr <= memspace_pkg::SRAM_END;
    wire [10:0] sram_idx = 11'(eff_addr - memspace_pkg::SRAM_BASE);
    wire ptr_update = DATA_REQ && !STALL && !(in_sram && !sram_phase_reg)
        && (ADDR_MODE == 3'(memspace_pkg::PTR_POSTINC)
        || ADDR_MODE == 3'(memspace_pkg::PTR_PREDEC));
    wire [15:0] new_ptr =
        ADDR_MODE == 3'(memspace_pkg::PTR_PREDEC) ? pre_dec : post_inc;
    // unified i/o port: short i/o or data-space i/o
    wire dio = DATA_REQ && in_stdio && !STALL;
    wire sio = IO_REQ && !STALL;
    wire io_acc = dio || sio;
    wire [5:0] io_addr = dio ? data_to_io(eff_addr) : IO_ADDR;
    wire io_we = dio ? DATA_WE : IO_WE;
    wire bit_acc = sio && (BIT_SET || BIT_CLR || BIT_TEST)
        && IO_ADDR <= memspace_pkg::BIT_IO_LAST;
    wire [7:0] bit_mask = 8'h01 << BIT_NUM;
    wire ee_busy = ee_strobe_reg;
    logic [7:0] io_read;
    always_comb begin
        io_read = 8'h00;
        unique case (io_addr)
            memspace_pkg::IO_EE_CTRL:
                io_read = {2'h0, ee_mode_reg, 1'b0, ee_arm_reg,
                    ee_strobe_reg, 1'b0};
            memspace_pkg::IO_EE_DATA: io_read = ee_data_reg;
            memspace_pkg::IO_EE_PTR_LO: io_read = ee_ptr_reg[7:0];
            memspace_pkg::IO_EE_PTR_HI: io_read = {6'h00, ee_ptr_reg[9:8]};
            memspace_pkg::IO_GPIO0: io_read = gpio_reg[0];
            memspace_pkg::IO_GPIO1: io_read = gpio_reg[1];
            memspace_pkg::IO_GPIO2: io_read = gpio_reg[2];
            memspace_pkg::IO_FLAGS: io_read = flags_reg;
            default: io_read = 8'h00;
        endcase
    end
    // byte written: bit ops touch only the addressed bit
    wire [7:0] io_wval = bit_acc ? (BIT_SET ? (io_read | bit_mask)
        : (io_read & ~bit_mask)) : (dio ? WDATA : WDATA);
    wire io_write = io_acc && (bit_acc ? !BIT_TEST : io_we);
    wire [7:0] flag_clear = !io_write ? 8'h00
        : (bit_acc ? (BIT_SET ? bit_mask : 8'h00) : WDATA);
    wire ctrl_wr = io_write && io_addr == memspace_pkg::IO_EE_CTRL;
    wire arm_set = ctrl_wr && io_wval[memspace_pkg::EE_ARM_BIT];
    wire strobe_req = ctrl_wr && io_wval[memspace_pkg::EE_STROBE_BIT];
    wire read_req = ctrl_wr && io_wval[memspace_pkg::EE_READ_BIT]
        && !ee_busy;
    wire write_go = strobe_req && ee_arm_reg && !ee_busy;
    // data read mux
    logic [7:0] data_read;
    always_comb begin
        data_read = 8'h00;
        if (in_regs)
            data_read = reg_file[eff_addr[4:0]];
        else if (in_stdio)
            data_read = io_read;
        else if (in_extio)
            data_read = 8'h00;
        else if (in_sram)
            data_read = sram[sram_idx];
    end
    always_ff @(posedge CLOCK) begin
        instr_reg <= prog_mem[PC];
        if (PROG_LOAD)
            prog_mem[PROG_LOAD_ADDR] <= PROG_LOAD_DATA;
    end
    // register file and sram
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sram_phase_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (DATA_REQ && in_sram && !STALL)
                sram_phase_reg <= !sram_phase_reg;
            if (DATA_REQ && !STALL && (!in_sram || sram_phase_reg))
                rdata_reg <= data_read;
            else if (sio && !bit_acc)
                rdata_reg <= io_read;
        end
        if (DATA_REQ && DATA_WE && !STALL) begin
            if (in_regs)
                reg_file[eff_addr[4:0]] <= WDATA;
            else if (in_sram && sram_phase_reg)
                sram[sram_idx] <= WDATA;
        end
        if (ptr_update) begin
            reg_file[5'h1A + {2'h0, PTR_SEL, 1'b0}] <= new_ptr[7:0];
            reg_file[5'h1B + {2'h0, PTR_SEL, 1'b0}] <= new_ptr[15:8];
        end
    end
    // i/o registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gpio_reg[0] <= 8'h00;
            gpio_reg[1] <= 8'h00;
            gpio_reg[2] <= 8'h00;
            flags_reg <= 8'h00;
            ee_data_reg <= 8'h00;
            ee_ptr_reg <= 10'h000;
            skip_reg <= 1'b0;
        end else begin
            if (io_write && io_addr == memspace_pkg::IO_GPIO0)
                gpio_reg[0] <= io_wval;
            if (io_write && io_addr == memspace_pkg::IO_GPIO1)
                gpio_reg[1] <= io_wval;
            if (io_write && io_addr == memspace_pkg::IO_GPIO2)
                gpio_reg[2] <= io_wval;
            // set wins over clear
            flags_reg <= (flags_reg & ~((io_addr == memspace_pkg::IO_FLAGS)
                ? flag_clear : 8'h00)) | FLAG_EVENTS;
            if (io_write && io_addr == memspace_pkg::IO_EE_DATA)
                ee_data_reg <= io_wval;
            else if (read_req)
                ee_data_reg <= ee_mem[ee_ptr_reg];
            if (io_write && !ee_busy && io_addr == memspace_pkg::IO_EE_PTR_LO)
                ee_ptr_reg[7:0] <= io_wval;
            if (io_write && !ee_busy && io_addr == memspace_pkg::IO_EE_PTR_HI)
                ee_ptr_reg[9:8] <= io_wval[1:0];
            skip_reg <= bit_acc && BIT_TEST
                && ((io_read & bit_mask) != 8'h00) == BIT_SET;
        end
    end
    // eeprom control, write survives reset
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ee_arm_reg <= 1'b0;
            arm_cnt_reg <= 3'h0;
            stall_reg <= 3'h0;
            if (!ee_busy)
                ee_mode_reg <= 2'h0;
        end else begin
            if (arm_set) begin
                ee_arm_reg <= 1'b1;
                arm_cnt_reg <= memspace_pkg::EE_ARM_WINDOW;
            end else if (arm_cnt_reg > ONE3)
                arm_cnt_reg <= arm_cnt_reg - ONE3;
            else begin
                ee_arm_reg <= 1'b0;
                arm_cnt_reg <= 3'h0;
            end
            if (ctrl_wr && !ee_busy)
                ee_mode_reg <= io_wval[memspace_pkg::EE_MODE_HI:
                    memspace_pkg::EE_MODE_LO];
            if (read_req)
                stall_reg <= memspace_pkg::EE_READ_STALL;
            else if (write_go)
                stall_reg <= memspace_pkg::EE_WRITE_STALL;
            else if (stall_reg != 3'h0)
                stall_reg <= stall_reg - ONE3;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (write_go && !RST) begin
            ee_strobe_reg <= 1'b1;
            wr_cnt_reg <= 32'(EE_WRITE_TIME);
            wr_addr_reg <= ee_ptr_reg;
            wr_data_reg <= ee_data_reg;
        end else if (ee_strobe_reg) begin
            if (wr_cnt_reg <= 32'h1) begin
                ee_strobe_reg <= 1'b0;
                wr_cnt_reg <= 32'h0;
                ee_mem[wr_addr_reg] <= wr_data_reg;
            end else
                wr_cnt_reg <= wr_cnt_reg - 32'h1;
        end else if (RST) begin
            ee_strobe_reg <= 1'b0;
            wr_cnt_reg <= 32'h0;
            wr_addr_reg <= 10'h000;
            wr_data_reg <= 8'h00;
        end
    end
    assign INSTR = instr_reg;
    assign RDATA = rdata_reg;
    assign SKIP = skip_reg;
    assign REG_OUT = gpio_reg[0];
    assign STALL = stall_reg != 3'h0;
    assign EE_BUSY = ee_busy;
    a_read_stall: assert property (@(posedge CLOCK) disable iff (RST)
        read_req |=> STALL [*4] ##1 !STALL)
        else $error("eeprom read stall not four cycles");
    a_write_stall: assert property (@(posedge CLOCK) disable iff (RST)
        write_go && !read_req |=> STALL [*2] ##1 !STALL)
        else $error("eeprom write stall not two cycles");
    a_unarmed_write: assert property (@(posedge CLOCK) disable iff (RST)
        strobe_req && !ee_arm_reg && !ee_busy |=> !ee_busy)
        else $error("unarmed strobe started a write");
    a_arm_timeout: assert property (@(posedge CLOCK) disable iff (RST)
        arm_set ##1 !arm_set [*4] |=> !ee_arm_reg)
        else $error("arm bit not cleared after four cycles");
    a_arm_holds: assert property (@(posedge CLOCK) disable iff (RST)
        arm_set |=> ee_arm_reg [*4])
        else $error("arm bit dropped inside its window");
    a_write_busy: assert property (@(posedge CLOCK) disable iff (RST)
        write_go |=> ee_busy)
        else $error("write did not show busy");
    a_sram_two: assert property (@(posedge CLOCK) disable iff (RST)
        DATA_REQ && in_sram && !sram_phase_reg && !STALL
        |=> sram_phase_reg)
        else $error("sram access not two cycles");
    a_past_end: assert property (@(posedge CLOCK) disable iff (RST)
        DATA_REQ && !STALL && eff_addr > memspace_pkg::SRAM_END
        && !in_regs |=> RDATA == 8'h00)
        else $error("read past sram end not zero");
    a_bit_only: assert property (@(posedge CLOCK) disable iff (RST)
        bit_acc && BIT_SET && !BIT_TEST && IO_ADDR == memspace_pkg::IO_GPIO0
        && !dio
        |=> gpio_reg[0] == ($past(gpio_reg[0]) | $past(bit_mask)))
        else $error("bit set disturbed other bits");
endmodule
